// [inc/lgd_pkg.sv]
// Purpose: Shared constants for the logic gate and delay timer module
// Assumes: 125 MHz clock, register port with one-cycle read latency
// Notes:   Delays are whole seconds counted on a one-second tick
package lgd_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned TICK_MS       = 1000;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

    // Channel counts
    localparam int unsigned NCH           = 16;
    localparam int unsigned NCH_NARROW    = 8;
    localparam int unsigned NGATE_IN      = 4;

    // Electrical levels in millivolts
    localparam logic [15:0] IN_HIGH_MV    = 16'd10000;
    localparam int unsigned OUT_HIGH_MV   = 24000;

    // Delay fields, seconds
    localparam int unsigned DLY_W         = 7;
    localparam logic [6:0]  DLY_MAX_S     = 7'd100;
    localparam logic [6:0]  ON_DLY_RST    = 7'd3;
    localparam logic [6:0]  OFF_DLY_RST   = 7'd3;
    localparam logic [6:0]  ONOFF_ON_RST  = 7'd3;
    localparam logic [6:0]  ONOFF_OFF_RST = 7'd6;

    // Register offsets (byte addresses)
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_MEM_INIT  = 8'h04;
    localparam logic [7:0]  REG_CONN      = 8'h08;
    localparam logic [7:0]  REG_ON_DLY    = 8'h0c;
    localparam logic [7:0]  REG_OFF_DLY   = 8'h10;
    localparam logic [7:0]  REG_ONOFF_ON  = 8'h14;
    localparam logic [7:0]  REG_ONOFF_OFF = 8'h18;
    localparam logic [7:0]  REG_IN_STAT   = 8'h1c;
    localparam logic [7:0]  REG_OUT_STAT  = 8'h20;

    // Control fields and reset values
    localparam int unsigned CTRL_WIDE_BIT = 0;
    localparam int unsigned CTRL_START_BIT = 1;
    localparam logic        CTRL_WIDE_RST = 1'b1;
    localparam logic [15:0] MEM_INIT_RST  = 16'h0000;
    localparam logic [3:0]  CONN_RST      = 4'hf;

    // Output map of the internal circuit
    localparam int unsigned Q_AND      = 0;
    localparam int unsigned Q_AND_EDGE = 1;
    localparam int unsigned Q_NAND     = 2;
    localparam int unsigned Q_NAND_EDGE = 3;
    localparam int unsigned Q_OR       = 4;
    localparam int unsigned Q_NOR      = 5;
    localparam int unsigned Q_XOR      = 6;
    localparam int unsigned Q_NOT      = 7;
    localparam int unsigned Q_ON_DLY   = 8;
    localparam int unsigned Q_OFF_DLY  = 9;
    localparam int unsigned Q_ONOFF    = 10;
    localparam int unsigned Q_MEM0     = 11;
    localparam int unsigned NMEM       = 5;

    // Input map of the internal circuit
    localparam int unsigned I_ON_TRG    = 4;
    localparam int unsigned I_OFF_TRG   = 5;
    localparam int unsigned I_OFF_RST   = 6;
    localparam int unsigned I_ONOFF_TRG = 7;
    localparam int unsigned I_MEM0      = 8;

    typedef enum logic [1:0] {
        LGD_IDLE,
        LGD_ON_WAIT,
        LGD_OFF_WAIT
    } lgd_phase_t;

endpackage : lgd_pkg

// [rtl/lgd_logic_module.sv]
// Purpose: Cycle-evaluated digital module with gates, memory bits and delay timers
// Assumes: Input levels arrive as sampled millivolt codes synchronous to clk
// Notes:   One clock cycle is one evaluation cycle; rst acts as simulation start
//
// Overview of operation
// - Input reads logic_high when its connector level exceeds 10 V.
// - A logic_high output drives its connector to 24 V, else no drive.
// - Memory bits show initial state at start, then copy their input.
// - AND is high only when all inputs high; unconnected inputs high.
// - Edge AND high when all high now and one was low before.
// - NAND low only when all inputs high; unconnected inputs high.
// - Edge NAND high when one low now and all were high before.
// - OR high when any input high; unconnected inputs low.
// - NOR high only while all inputs low; unconnected inputs low.
// - XOR high when its inputs differ; unconnected inputs low.
// - NOT output is the inverse of its single input.
// - On-delay starts on trigger rise, output high at expiry if held.
// - On-delay clears time on early fall; output low while trigger low.
// - Off-delay output rises with trigger; falls at expiry after trigger fall.
// - Retriggering during off-delay restarts the full delay from zero.
// - Off-delay reset clears time and forces output low.
// - On/off timer on-delay from rising trigger, cleared on early fall.
// - On/off timer off-delay from falling trigger, cleared on early rise.
// - Module runs with either 8 or 16 inputs and outputs.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module lgd_logic_module
    import lgd_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] in_level_mv [NCH],
    output logic [NCH-1:0]   out_drive,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata
);

    // Delay expiry test shared by all timers
    function automatic logic dly_done(input logic [DLY_W-1:0] cnt,
                                      input logic [DLY_W-1:0] dly);
        dly_done = (cnt >= dly);
    endfunction : dly_done

    // Saturating elapsed-time step
    function automatic logic [DLY_W-1:0] dly_step(input logic [DLY_W-1:0] cnt,
                                                  input logic             tick);
        dly_step = (tick && cnt != DLY_MAX_S) ? cnt + 7'd1 : cnt;
    endfunction : dly_step

    // Delay writes use the low seven bits; values above 100 are clamped
    function automatic logic [DLY_W-1:0] dly_clip(input logic [31:0] wd);
        dly_clip = (wd[DLY_W-1:0] > DLY_MAX_S) ? DLY_MAX_S : wd[DLY_W-1:0];
    endfunction : dly_clip

    logic                  wide;
    logic                  restart;
    logic [NCH-1:0]        mem_init;
    logic [NGATE_IN-1:0]   conn;
    logic [DLY_W-1:0]      on_dly;
    logic [DLY_W-1:0]      off_dly;
    logic [DLY_W-1:0]      onoff_on_dly;
    logic [DLY_W-1:0]      onoff_off_dly;
    logic [NCH-1:0]        din;
    logic [NCH-1:0]        din_prev;
    logic [NCH-1:0]        next_out;
    logic [31:0]           tick_cnt;
    logic                  tick;
    logic                  start;
    logic [NGATE_IN-1:0]   g_hi;
    logic [NGATE_IN-1:0]   g_hi_prev;
    logic [NGATE_IN-1:0]   g_lo;
    logic [DLY_W-1:0]      on_cnt;
    logic                  on_q;
    logic [DLY_W-1:0]      off_cnt;
    logic                  off_run;
    logic                  off_q;
    logic [DLY_W-1:0]      oo_cnt;
    logic                  oo_q;
    lgd_phase_t            oo_phase;
    logic [NMEM-1:0]       mem_q;

    // Reset or a software start both act as simulation start
    assign start = rst | restart;

    // Register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            wide          <= CTRL_WIDE_RST;
            mem_init      <= MEM_INIT_RST;
            conn          <= CONN_RST;
            on_dly        <= ON_DLY_RST;
            off_dly       <= OFF_DLY_RST;
            onoff_on_dly  <= ONOFF_ON_RST;
            onoff_off_dly <= ONOFF_OFF_RST;
        end else if (reg_write) begin
            case (reg_addr)
                REG_CTRL:      wide          <= reg_wdata[CTRL_WIDE_BIT];
                REG_MEM_INIT:  mem_init      <= reg_wdata[NCH-1:0];
                REG_CONN:      conn          <= reg_wdata[NGATE_IN-1:0];
                REG_ON_DLY:    on_dly        <= dly_clip(reg_wdata);
                REG_OFF_DLY:   off_dly       <= dly_clip(reg_wdata);
                REG_ONOFF_ON:  onoff_on_dly  <= dly_clip(reg_wdata);
                REG_ONOFF_OFF: onoff_off_dly <= dly_clip(reg_wdata);
                default: ;
            endcase
        end
    end

    // Start strobe is self-clearing
    always_ff @(posedge clk) begin
        if (rst) begin
            restart <= 1'b0;
        end else begin
            restart <= reg_write && reg_addr == REG_CTRL && reg_wdata[CTRL_START_BIT];
        end
    end

    // Read data stand for one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_read) begin
            case (reg_addr)
                REG_CTRL:      reg_rdata <= {31'h0, wide};
                REG_MEM_INIT:  reg_rdata <= {16'h0, mem_init};
                REG_CONN:      reg_rdata <= {28'h0, conn};
                REG_ON_DLY:    reg_rdata <= {25'h0, on_dly};
                REG_OFF_DLY:   reg_rdata <= {25'h0, off_dly};
                REG_ONOFF_ON:  reg_rdata <= {25'h0, onoff_on_dly};
                REG_ONOFF_OFF: reg_rdata <= {25'h0, onoff_off_dly};
                REG_IN_STAT:   reg_rdata <= {16'h0, din};
                REG_OUT_STAT:  reg_rdata <= {16'h0, out_drive};
                default:       reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // One-second time base; restarted so the first tick is a full period
    always_ff @(posedge clk) begin
        if (start || tick_cnt >= TICK_LEN - 1) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    assign tick = (tick_cnt >= TICK_LEN - 1) && !start;

    // Input threshold; upper half reads low in narrow mode
    always_ff @(posedge clk) begin
        if (rst) begin
            din      <= '0;
            din_prev <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                din[i] <= (in_level_mv[i] > IN_HIGH_MV) && (wide || i < NCH_NARROW);
            end
            din_prev <= din;
        end
    end

    // Gate inputs: unconnected reads high for AND types, low for OR types
    always_comb begin
        g_hi      = din[NGATE_IN-1:0] | ~conn;
        g_hi_prev = din_prev[NGATE_IN-1:0] | ~conn;
        g_lo      = din[NGATE_IN-1:0] & conn;
    end

    // On-delay timer
    always_ff @(posedge clk) begin
        if (start) begin
            on_cnt <= '0;
            on_q   <= 1'b0;
        end else if (!din[I_ON_TRG]) begin
            on_cnt <= '0;
            on_q   <= 1'b0;
        end else if (!din_prev[I_ON_TRG]) begin
            on_cnt <= '0;
        end else if (!on_q && dly_done(on_cnt, on_dly)) begin
            on_q <= 1'b1;
        end else begin
            on_cnt <= dly_step(on_cnt, tick);
        end
    end

    // Off-delay timer; its reset input wins over the trigger
    always_ff @(posedge clk) begin
        if (start || din[I_OFF_RST]) begin
            off_cnt <= '0;
            off_run <= 1'b0;
            off_q   <= 1'b0;
        end else if (din[I_OFF_TRG]) begin
            off_cnt <= '0;
            off_run <= 1'b0;
            off_q   <= 1'b1;
        end else if (din_prev[I_OFF_TRG]) begin
            off_cnt <= '0;
            off_run <= off_q;
        end else if (off_run && dly_done(off_cnt, off_dly)) begin
            off_run <= 1'b0;
            off_q   <= 1'b0;
        end else if (off_run) begin
            off_cnt <= dly_step(off_cnt, tick);
        end
    end

    // Combined on/off-delay timer
    always_ff @(posedge clk) begin
        if (start) begin
            oo_phase <= LGD_IDLE;
            oo_cnt   <= '0;
            oo_q     <= 1'b0;
        end else if (din[I_ONOFF_TRG] && !din_prev[I_ONOFF_TRG]) begin
            oo_phase <= oo_q ? LGD_IDLE : LGD_ON_WAIT;
            oo_cnt   <= '0;
        end else if (!din[I_ONOFF_TRG] && din_prev[I_ONOFF_TRG]) begin
            oo_phase <= oo_q ? LGD_OFF_WAIT : LGD_IDLE;
            oo_cnt   <= '0;
        end else begin
            case (oo_phase)
                LGD_ON_WAIT: begin
                    if (dly_done(oo_cnt, onoff_on_dly)) begin
                        oo_q     <= 1'b1;
                        oo_phase <= LGD_IDLE;
                    end else begin
                        oo_cnt <= dly_step(oo_cnt, tick);
                    end
                end
                LGD_OFF_WAIT: begin
                    if (dly_done(oo_cnt, onoff_off_dly)) begin
                        oo_q     <= 1'b0;
                        oo_phase <= LGD_IDLE;
                    end else begin
                        oo_cnt <= dly_step(oo_cnt, tick);
                    end
                end
                default: oo_phase <= LGD_IDLE;
            endcase
        end
    end

    // Memory bits: start loads the initial state, input ignored that cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_q <= MEM_INIT_RST[Q_MEM0 +: NMEM];
        end else if (restart) begin
            mem_q <= mem_init[Q_MEM0 +: NMEM];
        end else begin
            mem_q <= din[I_MEM0 +: NMEM];
        end
    end

    // Output vector of the internal circuit
    always_comb begin
        next_out              = '0;
        next_out[Q_AND]       = &g_hi;
        next_out[Q_AND_EDGE]  = &g_hi && !(&g_hi_prev);
        next_out[Q_NAND]      = !(&g_hi);
        next_out[Q_NAND_EDGE] = !(&g_hi) && &g_hi_prev;
        next_out[Q_OR]        = |g_lo;
        next_out[Q_NOR]       = !(|g_lo);
        next_out[Q_XOR]       = g_lo[0] ^ g_lo[1];
        next_out[Q_NOT]       = !din[0];
        next_out[Q_ON_DLY]    = on_q;
        next_out[Q_OFF_DLY]   = off_q;
        next_out[Q_ONOFF]     = oo_q;
        next_out[Q_MEM0 +: NMEM] = mem_q;
        if (!wide) begin
            next_out[NCH-1:NCH_NARROW] = '0;
        end
    end

    // Drive enable for the 24 V output stage; off during reset
    always_ff @(posedge clk) begin
        if (start) begin
            out_drive <= '0;
        end else begin
            out_drive <= next_out;
        end
    end

endmodule : lgd_logic_module

// [dv/lgd_chk.sv]
// Purpose: Port-level checker for the logic gate and delay timer module
// Assumes: Register writes settle within seven cycles
// Notes:   Gate checks pause after any write, since a start or mask change shifts the pipeline
`timescale 1ns/1ps
module lgd_chk
    import lgd_pkg::*;
(
    input wire logic           clk,
    input wire logic           rst,
    input wire logic [15:0]    in_level_mv [NCH],
    input wire logic [NCH-1:0] out_drive,
    input wire logic [7:0]     reg_addr,
    input wire logic [31:0]    reg_wdata,
    input wire logic           reg_write,
    input wire logic           reg_read,
    input wire logic [31:0]    reg_rdata
);
    logic [7:0] hi;
    logic [3:0] conn;
    logic [3:0] ah;
    logic [3:0] oh;
    logic [2:0] settle;
    logic       wide;
    logic       ok;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            hi[i] = in_level_mv[i] > IN_HIGH_MV;
        end
    end
    // Unconnected inputs read high for the AND family, low for the OR family
    assign ah = hi[3:0] | ~conn;
    assign oh = hi[3:0] & conn;
    assign ok = settle == 3'h7;
    always_ff @(posedge clk) begin
        if (rst) begin
            settle <= 3'h0;
            conn   <= CONN_RST;
            wide   <= CTRL_WIDE_RST;
        end else if (reg_write) begin
            settle <= 3'h0;
            if (reg_addr == REG_CONN) conn <= reg_wdata[3:0];
            if (reg_addr == REG_CTRL) wide <= reg_wdata[CTRL_WIDE_BIT];
        end else if (settle != 3'h7) begin
            settle <= settle + 3'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_and; ok |-> out_drive[Q_AND] == &$past(ah, 2); endproperty
    a_and: assert property (p_and) else $error("and output wrong");
    property p_and_edge; ok |-> out_drive[Q_AND_EDGE] == (&$past(ah, 2) && !(&$past(ah, 3)));
    endproperty
    a_and_edge: assert property (p_and_edge) else $error("edge and wrong");
    property p_nand; ok |-> out_drive[Q_NAND] == !(&$past(ah, 2)); endproperty
    a_nand: assert property (p_nand) else $error("nand output wrong");
    property p_nand_edge; ok |-> out_drive[Q_NAND_EDGE] == (!(&$past(ah, 2)) && &$past(ah, 3));
    endproperty
    a_nand_edge: assert property (p_nand_edge) else $error("edge nand wrong");
    property p_or; ok |-> out_drive[Q_OR] == |$past(oh, 2); endproperty
    a_or: assert property (p_or) else $error("or output wrong");
    property p_nor; ok |-> out_drive[Q_NOR] == !(|$past(oh, 2)); endproperty
    a_nor: assert property (p_nor) else $error("nor output wrong");
    property p_xor; ok |-> out_drive[Q_XOR] == ^$past(oh[1:0], 2); endproperty
    a_xor: assert property (p_xor) else $error("xor output wrong");
    property p_not; ok |-> out_drive[Q_NOT] != $past(hi[0], 2); endproperty
    a_not: assert property (p_not) else $error("inverter output wrong");
    property p_narrow; ok && !wide |-> out_drive[15:8] == 8'h0; endproperty
    a_narrow: assert property (p_narrow) else $error("upper outputs in narrow mode");
    property p_rd_idle; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
    // Timer outputs lag the gates by one cycle, behind their own state flop
    property p_on_low; ok && !$past(hi[I_ON_TRG], 3) |-> !out_drive[Q_ON_DLY]; endproperty
    a_on_low: assert property (p_on_low) else $error("on delay high with trigger low");
    property p_off_rst; ok && $past(hi[I_OFF_RST], 3) |-> !out_drive[Q_OFF_DLY]; endproperty
    a_off_rst: assert property (p_off_rst) else $error("off delay high in reset");
    // Narrow mode forces the upper outputs low, so the set check needs wide mode
    property p_off_set;
        ok && wide && $past(hi[I_OFF_TRG], 3) && !$past(hi[I_OFF_RST], 3) |-> out_drive[Q_OFF_DLY];
    endproperty
    a_off_set: assert property (p_off_set) else $error("off delay not set by trigger");
    c_on: cover property (ok && out_drive[Q_ON_DLY]);
    c_onoff: cover property (out_drive[Q_ONOFF]);
    c_off_fall: cover property ($fell(out_drive[Q_OFF_DLY]));
endmodule : lgd_chk

bind lgd_logic_module lgd_chk chk_u (.clk(clk), .rst(rst), .in_level_mv(in_level_mv),
    .out_drive(out_drive), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

// [dv/lgd_circuit.sv]
// Purpose: Surrounding circuit that drives the module input connectors
// Assumes: The bench names the wanted logic level of each connector
// Notes:   Levels swap between threshold edge and full swing every cycle
`timescale 1ns/1ps
module lgd_circuit
    import lgd_pkg::*;
(
    input  wire logic [0:0]     clk,
    input  wire logic [NCH-1:0] want,
    output logic [15:0]         level_mv [NCH]
);
    logic flip = 1'b0;
    initial level_mv = '{default: 16'h0};
    always @(posedge clk) begin
        flip <= ~flip;
        for (int i = 0; i < NCH; i++) begin
            // Exactly 10 V must still read low, so the threshold is probed both sides
            level_mv[i] <= want[i] ? (flip ? IN_HIGH_MV + 16'h1 : 16'(OUT_HIGH_MV))
                                   : (flip ? IN_HIGH_MV : 16'h0);
        end
    end
endmodule : lgd_circuit

// [dv/testbench.sv]
// Purpose: Self-checking bench for the logic gate and delay timer module
// Assumes: Ten-cycle time base; delays of 1 to 3 ticks
// Notes:   Timer windows allow for the tick base running free of the trigger
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench
    import lgd_pkg::*;
;
    localparam int unsigned TL = 10;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic [NCH-1:0] want = 16'h0;
    logic [15:0]    level_mv [NCH];
    logic [NCH-1:0] out_drive;
    logic [7:0]     reg_addr = 8'h0;
    logic [31:0]    reg_wdata = 32'h0;
    logic           reg_write = 1'b0;
    logic           reg_read = 1'b0;
    logic [31:0]    reg_rdata;
    logic [31:0]    rv;
    logic [3:0]     cn;
    logic [3:0]     hits;
    int             errors = 0;
    int             num_checks = 0;
    int             cycles = 0;
    int             seed = 32'hc602;
    logic [7:0]     ra [8] = '{REG_CTRL, REG_MEM_INIT, REG_CONN, REG_ON_DLY, REG_OFF_DLY,
                               REG_ONOFF_ON, REG_ONOFF_OFF, 8'h24};
    logic [31:0]    rx [8] = '{32'h1, 32'h0, 32'hf, 32'h3, 32'h3, 32'h3, 32'h6, 32'h0};
    always #4 clk = ~clk;
    lgd_circuit env_u (.clk(clk), .want(want), .level_mv(level_mv));
    lgd_logic_module #(.TICK_LEN(TL)) dut_u (.clk(clk), .rst(rst), .in_level_mv(level_mv),
        .out_drive(out_drive), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // A hung handshake must still reach the verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        // Roughly six times the expected run length
        if (cycles == 4000) begin
            errors++;
            tally_and_finish();
        end
    end
    function automatic logic [7:0] gates(input logic [3:0] a, input logic [3:0] c);
        gates = {~a[0], ^(a[1:0] & c[1:0]), ~|(a & c), |(a & c), 1'b0, ~&(a | ~c), 1'b0,
                 &(a | ~c)};
    endfunction : gates
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic setw(input logic [NCH-1:0] v);
        @(posedge clk);
        want <= v;
    endtask : setw
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
        `CHK("register read", e, rv)
    endtask : rd
    task automatic at(input int idx, input int n, input logic e);
        cyc(n);
        #1 `CHK("timer output", e, out_drive[idx])
    endtask : at
    task automatic count(input int idx);
        hits = 4'h0;
        repeat (8) begin
            @(posedge clk);
            #1 hits = hits + {3'h0, out_drive[idx]};
        end
    endtask : count
    initial begin
        cyc(8);
        rst <= 1'b0;
        #1 `CHK("outputs after reset", 16'h0, out_drive)
        for (int i = 0; i < 8; i++) rd(ra[i], rx[i]);
        wr(REG_ON_DLY, 32'h78);
        rd(REG_ON_DLY, 32'h64);
        wr(REG_ON_DLY, 32'h2);
        wr(REG_OFF_DLY, 32'h2);
        wr(REG_ONOFF_ON, 32'h1);
        wr(REG_ONOFF_OFF, 32'h3);
        $display("test registers done");
        for (int k = 0; k < 40; k++) begin
            cn = (k < 2) ? 4'hf : 4'($random(seed));
            wr(REG_CONN, {28'h0, cn});
            setw((k == 0) ? 16'h0 : (k == 1) ? 16'hffff : 16'($random(seed)));
            cyc(5);
            #1 `CHK("gates", gates(want[3:0], cn), out_drive[7:0])
            rd(REG_IN_STAT, {16'h0, want});
        end
        wr(REG_CONN, 32'hf);
        setw(16'h0);
        cyc(4);
        setw(16'h000f);
        count(Q_AND_EDGE);
        `CHK("edge and pulses", 4'h1, hits)
        setw(16'h0);
        count(Q_NAND_EDGE);
        `CHK("edge nand pulses", 4'h1, hits)
        $display("test gates done");
        wr(REG_CTRL, 32'h0);
        setw(16'hffff);
        cyc(5);
        #1 `CHK("narrow outputs", 8'h0, out_drive[15:8])
        rd(REG_IN_STAT, 32'hff);
        wr(REG_CTRL, 32'h1);
        setw(16'h0);
        wr(REG_MEM_INIT, 32'h5000);
        wr(REG_CTRL, 32'h3);
        hits = 4'h0;
        repeat (4) begin
            @(posedge clk);
            #1 if (out_drive[15:11] === 5'h0a) hits = hits + 4'h1;
        end
        `CHK("memory start state", 1'b1, hits != 4'h0)
        setw(16'h1f00);
        cyc(5);
        #1 `CHK("memory copies input", 5'h1f, out_drive[15:11])
        // Memory bits high; NAND, NOR and NOT high with all gate inputs low
        rd(REG_OUT_STAT, 32'hf8a4);
        $display("test memory done");
        setw(16'h0);
        cyc(4);
        setw(16'h0010);
        at(Q_ON_DLY, 9, 1'b0);
        at(Q_ON_DLY, 16, 1'b1);
        setw(16'h0);
        cyc(4);
        setw(16'h0010);
        cyc(7);
        setw(16'h0);
        cyc(2);
        setw(16'h0010);
        at(Q_ON_DLY, 9, 1'b0);
        setw(16'h0020);
        at(Q_OFF_DLY, 4, 1'b1);
        setw(16'h0);
        at(Q_OFF_DLY, 9, 1'b1);
        at(Q_OFF_DLY, 16, 1'b0);
        setw(16'h0020);
        cyc(2);
        setw(16'h0);
        cyc(8);
        setw(16'h0020);
        setw(16'h0);
        at(Q_OFF_DLY, 9, 1'b1);
        at(Q_OFF_DLY, 16, 1'b0);
        setw(16'h0020);
        cyc(3);
        setw(16'h0040);
        at(Q_OFF_DLY, 4, 1'b0);
        setw(16'h0080);
        at(Q_ONOFF, 15, 1'b1);
        setw(16'h0);
        cyc(17);
        setw(16'h0080);
        cyc(2);
        setw(16'h0);
        at(Q_ONOFF, 19, 1'b1);
        at(Q_ONOFF, 16, 1'b0);
        $display("test timers done");
        tally_and_finish();
    end
endmodule : testbench
